// file: rtl/pipr_pkg.sv
`default_nettype none
package pipr_pkg;

  // Register bus widths.
  localparam int ADDR_W  = 5;
  localparam int DATA_W  = 8;
  localparam int NUM_SEL = 19;
  localparam int CODE_W  = 5;

  // Pin code layout: port in bits 4:3, pin index in bits 2:0.
  localparam int CODE_PORT_MSB = 4;
  localparam int CODE_PORT_LSB = 3;
  localparam int CODE_PIN_MSB  = 2;

  localparam logic [1:0] PORT_A = 2'h0;
  localparam logic [1:0] PORT_B = 2'h1;
  localparam logic [1:0] PORT_C = 2'h2;

  // Permitted-port mask bits, one per port.
  localparam int OK_A = 0;
  localparam int OK_B = 1;
  localparam int OK_C = 2;

  // Register offsets; for the selection registers the offset is also the input index.
  localparam logic [4:0] OFS_EDGE_IRQ      = 5'h00;
  localparam logic [4:0] OFS_TIMER0_CLOCK  = 5'h01;
  localparam logic [4:0] OFS_TIMER1_CLOCK  = 5'h02;
  localparam logic [4:0] OFS_TIMER1_GATE   = 5'h03;
  localparam logic [4:0] OFS_TIMER2_EXT    = 5'h04;
  localparam logic [4:0] OFS_TIMER3_CLOCK  = 5'h05;
  localparam logic [4:0] OFS_TIMER3_GATE   = 5'h06;
  localparam logic [4:0] OFS_TIMER4_EXT    = 5'h07;
  localparam logic [4:0] OFS_TIMER5_CLOCK  = 5'h08;
  localparam logic [4:0] OFS_TIMER5_GATE   = 5'h09;
  localparam logic [4:0] OFS_TIMER6_EXT    = 5'h0a;
  localparam logic [4:0] OFS_MOD_CARR_LOW  = 5'h0b;
  localparam logic [4:0] OFS_MOD_CARR_HIGH = 5'h0c;
  localparam logic [4:0] OFS_MOD_SOURCE    = 5'h0d;
  localparam logic [4:0] OFS_CAPTURE1      = 5'h0e;
  localparam logic [4:0] OFS_CAPTURE2      = 5'h0f;
  localparam logic [4:0] OFS_CAPTURE3      = 5'h10;
  localparam logic [4:0] OFS_CAPTURE4      = 5'h11;
  localparam logic [4:0] OFS_WAVEFORM_GEN1 = 5'h12;
  localparam logic [4:0] OFS_PORT_A_LEVEL  = 5'h14;
  localparam logic [4:0] OFS_PORT_B_LEVEL  = 5'h15;
  localparam logic [4:0] OFS_PORT_C_LEVEL  = 5'h16;

  // Reset codes, index 18 first.
  localparam logic [NUM_SEL-1:0][CODE_W-1:0] RST_CODE = {
    5'h02, 5'h04, 5'h02, 5'h13, 5'h15, 5'h01, 5'h15, 5'h12, 5'h12, 5'h13,
    5'h10, 5'h11, 5'h14, 5'h15, 5'h05, 5'h04, 5'h05, 5'h02, 5'h02};

  // Permitted ports {C,B,A}, index 18 first.
  localparam logic [NUM_SEL-1:0][2:0] PORT_OK = {
    3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h5, 3'h5, 3'h5, 3'h6, 3'h6,
    3'h5, 3'h6, 3'h5, 3'h6, 3'h5, 3'h6, 3'h5, 3'h3, 3'h3};

  // Bonded pins per package variant.
  localparam logic [7:0] PINS_A        = 8'h3f;
  localparam logic [7:0] PINS_B_WIDE   = 8'hf0;
  localparam logic [7:0] PINS_B_NARROW = 8'h00;
  localparam logic [7:0] PINS_C_WIDE   = 8'hff;
  localparam logic [7:0] PINS_C_NARROW = 8'h3f;

  typedef struct packed {
    logic [7:0] port_c;
    logic [7:0] port_b;
    logic [7:0] port_a;
  } pipr_pins_t;

endpackage : pipr_pkg
`default_nettype wire

// file: rtl/pipr_sel_reg.sv
`default_nettype none
module pipr_sel_reg #(
  parameter logic [4:0] RST_VAL = 5'h00
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_we,
  input  wire logic [4:0] i_wdata,
  output logic      [4:0] o_code
);

  // Holds one selection code; reset loads the input's own default.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_code <= RST_VAL;
    end else if (i_we) begin
      o_code <= i_wdata;
    end
  end

endmodule : pipr_sel_reg
`default_nettype wire

// file: rtl/pipr_route.sv
`default_nettype none
module pipr_route #(
  parameter logic [2:0] PORT_OK = 3'h7
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_b,
  input  wire logic [4:0]           i_code,
  input  wire pipr_pkg::pipr_pins_t i_pins,
  output logic                      o_level
);

  logic [1:0] port;
  logic [2:0] pin_idx;
  logic       level_nxt;

  // Decodes the shared code set and gates off ports not offered here.
  always_comb begin
    port    = i_code[pipr_pkg::CODE_PORT_MSB:pipr_pkg::CODE_PORT_LSB];
    pin_idx = i_code[pipr_pkg::CODE_PIN_MSB:0];
    case (port)
      pipr_pkg::PORT_A: begin
        level_nxt = PORT_OK[pipr_pkg::OK_A] & i_pins.port_a[pin_idx];
      end
      pipr_pkg::PORT_B: begin
        level_nxt = PORT_OK[pipr_pkg::OK_B] & i_pins.port_b[pin_idx];
      end
      pipr_pkg::PORT_C: begin
        level_nxt = PORT_OK[pipr_pkg::OK_C] & i_pins.port_c[pin_idx];
      end
      default: begin
        level_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_level <= 1'b0;
    end else begin
      o_level <= level_nxt;
    end
  end

endmodule : pipr_route
`default_nettype wire

// file: rtl/pipr_top.sv
// Notes on behaviour
// R1: Only digital pin levels are routed from pins to peripheral inputs.
// R2: Analog pin functions bypass the routing and stay tied to their own pins.
// R3: Input routing is independent of any output routing and does not disturb it.
// R4: Each peripheral input owns one selection register whose low five bits pick its pin.
// R5: Every selection register decodes the same pin code set in the same way.
// R6: A selected pin is delivered only if its port is offered to that input, else zero.
// R7: Any number of inputs may select one pin and all see its level together.
// R8: Port reads return the true pin level whatever the routing.
// R9: Software clears a pin's analog select bit before using it as a routed digital input.
// R10: Codes carry the port in bits 4:3 (A=0, B=1, C=2) and the pin index in bits 2:0.
// R11: After reset each selection register holds its own default code for both package sizes.
//
// Implementation choices: the register addresses and the strobed register port.
`default_nettype none
module pipr_top #(
  parameter bit WIDE_PKG = 1'b1
) (
  input  wire logic                                   i_clk,
  input  wire logic                                   i_rst_b,
  input  wire logic [pipr_pkg::ADDR_W-1:0]            i_addr,
  input  wire logic [pipr_pkg::DATA_W-1:0]            i_wdata,
  input  wire logic                                   i_we,
  input  wire logic                                   i_re,
  output logic      [pipr_pkg::DATA_W-1:0]            o_rdata,
  input  wire pipr_pkg::pipr_pins_t                   i_pins,
  input  wire pipr_pkg::pipr_pins_t                   i_analog_sel,
  output pipr_pkg::pipr_pins_t                        o_port_level,
  output pipr_pkg::pipr_pins_t                        o_analog_pins,
  output logic      [pipr_pkg::NUM_SEL-1:0]           o_periph_in
);

  localparam int NSEL = pipr_pkg::NUM_SEL;

  logic [NSEL-1:0][pipr_pkg::CODE_W-1:0] sel_code;
  logic [NSEL-1:0]                       sel_we;
  pipr_pkg::pipr_pins_t                  pins_present;
  pipr_pkg::pipr_pins_t                  digital_pins;
  pipr_pkg::pipr_pins_t                  port_level_r;
  logic [pipr_pkg::DATA_W-1:0]           rdata_nxt;
  logic [pipr_pkg::DATA_W-1:0]           rdata_r;
  logic                                  sel_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Pin conditioning.

  // Only pins bonded in the chosen package exist; others read as zero.
  always_comb begin
    pins_present.port_a = pipr_pkg::PINS_A;
    if (WIDE_PKG) begin
      pins_present.port_b = pipr_pkg::PINS_B_WIDE;
      pins_present.port_c = pipr_pkg::PINS_C_WIDE;
    end else begin
      pins_present.port_b = pipr_pkg::PINS_B_NARROW;
      pins_present.port_c = pipr_pkg::PINS_C_NARROW;
    end
  end

  // An analog select bit turns off the digital input buffer of its pin.
  assign digital_pins = i_pins & ~i_analog_sel & pins_present; // R1

  // Analog functions see the raw pins, untouched by any selection code.
  assign o_analog_pins = i_pins; // R2

  ////////////////////////////////////////////////////////////////////////////
  // Port level readback.

  // Port level follows the pin alone; no selection register feeds it.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      port_level_r <= '0;
    end else begin
      port_level_r <= digital_pins; // R8
    end
  end

  assign o_port_level = port_level_r;

  ////////////////////////////////////////////////////////////////////////////
  // Selection registers and routing.

  // Writes above the last selection register never touch a code.
  assign sel_hit = (i_addr < pipr_pkg::ADDR_W'(NSEL));

  generate
    for (genvar g = 0; g < NSEL; g++) begin : g_sel
      assign sel_we[g] = i_we && (i_addr == pipr_pkg::ADDR_W'(g));

      pipr_sel_reg #(
        .RST_VAL (pipr_pkg::RST_CODE[g])                              // R11
      ) u_reg (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_we    (sel_we[g]),
        .i_wdata (i_wdata[pipr_pkg::CODE_W-1:0]),                     // R4
        .o_code  (sel_code[g])
      );

      // Each input has its own decoder fed by the shared pin set.
      pipr_route #(
        .PORT_OK (pipr_pkg::PORT_OK[g])                               // R6
      ) u_route (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_code  (sel_code[g]),                                       // R5
        .i_pins  (digital_pins),                                      // R7
        .o_level (o_periph_in[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register read port.

  // Codes read back in the low five bits, the upper bits as zero.
  always_comb begin
    rdata_nxt = '0;
    if (sel_hit) begin
      rdata_nxt = {3'h0, sel_code[i_addr]}; // R10
    end else begin
      case (i_addr)
        pipr_pkg::OFS_PORT_A_LEVEL: begin
          rdata_nxt = port_level_r.port_a;
        end
        pipr_pkg::OFS_PORT_B_LEVEL: begin
          rdata_nxt = port_level_r.port_b;
        end
        pipr_pkg::OFS_PORT_C_LEVEL: begin
          rdata_nxt = port_level_r.port_c;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_r <= '0;
    end else if (i_re) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end

  assign o_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge i_clk);
  endclocking

  default disable iff (!i_rst_b);

  logic [1:0] chk_port0;
  logic [2:0] chk_pin0;
  logic       chk_lvl0;

  // Reference level for input 0 from the raw pins and analog selects.
  always_comb begin
    chk_port0 = sel_code[0][pipr_pkg::CODE_PORT_MSB:pipr_pkg::CODE_PORT_LSB];
    chk_pin0  = sel_code[0][pipr_pkg::CODE_PIN_MSB:0];
    case (chk_port0)
      pipr_pkg::PORT_A: begin
        chk_lvl0 = i_pins.port_a[chk_pin0] & ~i_analog_sel.port_a[chk_pin0]
                 & pins_present.port_a[chk_pin0];
      end
      pipr_pkg::PORT_B: begin
        chk_lvl0 = i_pins.port_b[chk_pin0] & ~i_analog_sel.port_b[chk_pin0]
                 & pins_present.port_b[chk_pin0];
      end
      default: begin
        chk_lvl0 = 1'b0;
      end
    endcase
  end

  chk_write_code_lands: assert property ( // R4
    i_we && sel_hit |=> sel_code[$past(i_addr)] == $past(i_wdata[4:0])
  ) else $error("selection code did not take the written value");

  chk_code_readback: assert property ( // R10
    i_re && sel_hit && !i_we |=> o_rdata == {3'h0, $past(sel_code[i_addr])}
  ) else $error("selection readback wrong or upper bits not zero");

  chk_reset_defaults: assert property ( // R11
    $rose(i_rst_b) |-> sel_code == pipr_pkg::RST_CODE
  ) else $error("selection codes not at defaults after reset");

  chk_edge_irq_route: assert property ( // R5
    1'b1 |=> o_periph_in[0] == $past(chk_lvl0)
  ) else $error("edge input does not follow its selected pin");

  chk_port_not_offered: assert property ( // R6
    sel_code[3][4:3] == pipr_pkg::PORT_A |=> !o_periph_in[3]
  ) else $error("pin from a port not offered reached the input");

  chk_shared_pin: assert property ( // R7
    sel_code[14] == sel_code[15] |=> o_periph_in[14] == o_periph_in[15]
  ) else $error("two inputs on one pin disagree");

  chk_analog_blocks: assert property ( // R1
    i_analog_sel.port_a[sel_code[0][2:0]] && sel_code[0][4:3] == pipr_pkg::PORT_A
      |=> !o_periph_in[0]
  ) else $error("analog-selected pin reached a peripheral input");

  chk_port_read_true: assert property ( // R8
    1'b1 |=> o_port_level == $past(i_pins & ~i_analog_sel & pins_present)
  ) else $error("port level differs from pin level");

  chk_write_no_side: assert property ( // R3
    i_we && $stable(i_pins) && $stable(i_analog_sel) ##1 $stable(i_pins) && $stable(i_analog_sel)
      |-> $stable(o_port_level)
  ) else $error("selection write disturbed the port level");

  chk_analog_fixed: assert property ( // R2
    i_we |-> ##[0:2] o_analog_pins == i_pins
  ) else $error("analog pins moved with routing");

endmodule : pipr_top
`default_nettype wire

// file: tb/pipr_pad_model.sv
`default_nettype none
module pipr_pad_model (
  input  wire pipr_pkg::pipr_pins_t i_level,
  input  wire pipr_pkg::pipr_pins_t i_analog,
  output var  pipr_pkg::pipr_pins_t o_pins,
  output var  pipr_pkg::pipr_pins_t o_analog_sel
);
  // Pads hand their level straight in; software owns the analog select bits.
  assign o_pins       = i_level;
  assign o_analog_sel = i_analog;
endmodule : pipr_pad_model
`default_nettype wire

// file: tb/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////////////
  // Expected reset codes and permitted ports {C,B,A}, index 18 first.
  localparam logic [18:0][4:0] RST = {5'h02, 5'h04, 5'h02, 5'h13, 5'h15, 5'h01, 5'h15, 5'h12, 5'h12, 5'h13,
                                      5'h10, 5'h11, 5'h14, 5'h15, 5'h05, 5'h04, 5'h05, 5'h02, 5'h02};
  localparam logic [18:0][2:0] OKP = {3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h5, 3'h5, 3'h5, 3'h6, 3'h6,
                                      3'h5, 3'h6, 3'h5, 3'h6, 3'h5, 3'h6, 3'h5, 3'h3, 3'h3};
  logic                 clk   = 1'b0;
  logic                 rst_b = 1'b0;
  logic                 we    = 1'b0;
  logic                 re    = 1'b0;
  logic [4:0]           addr  = 5'h00;
  logic [7:0]           wdata = 8'h00;
  logic [7:0]           rdata;
  logic [7:0]           rd_v;
  pipr_pkg::pipr_pins_t level  = 24'h000000;
  pipr_pkg::pipr_pins_t analog = 24'h000000;
  pipr_pkg::pipr_pins_t pins;
  pipr_pkg::pipr_pins_t asel;
  pipr_pkg::pipr_pins_t port_level;
  pipr_pkg::pipr_pins_t analog_pins;
  logic [18:0]          periph;
  logic [18:0]          exp_p;
  int                   errors     = 0;
  int                   n_compared = 0;
  int                   cycles     = 0;
  ////////////////////////////////////////////////////////////////////////////////
  pipr_pad_model pad_u (.i_level(level), .i_analog(analog), .o_pins(pins), .o_analog_sel(asel));
  pipr_top #(.WIDE_PKG(1'b1)) dut_u (
    .i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_we(we), .i_re(re),
    .o_rdata(rdata), .i_pins(pins), .i_analog_sel(asel), .o_port_level(port_level),
    .o_analog_pins(analog_pins), .o_periph_in(periph));
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    we    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    re   <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  task automatic t_reset();
    for (int i = 0; i < 19; i++) begin
      rd(5'(i), rd_v);
      chk("reset code", {19'h00000, RST[i]}, {16'h0000, rd_v});
    end
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs();
    wr(5'h00, 8'hff);
    rd(5'h00, rd_v);
    chk("code field", 24'h00001f, {16'h0000, rd_v});
    @(posedge clk);
    #1;
    chk("read data gone", 24'h000000, {16'h0000, rdata});
    rd(5'h01, rd_v);
    chk("neighbour code", 24'h000002, {16'h0000, rd_v});
    wr(5'h14, 8'hff);
    rd(5'h14, rd_v);
    chk("read-only port", 24'h000000, {16'h0000, rd_v});
    rd(5'h1f, rd_v);
    chk("unmapped read", 24'h000000, {16'h0000, rd_v});
    $display("test registers done");
  endtask : t_regs
  task automatic t_route(input logic [4:0] c);
    logic [23:0] pv;
    pv = 24'h000001 << c;
    for (int i = 0; i < 19; i++) begin
      wr(5'(i), {3'h0, c});
    end
    @(posedge clk);
    level <= pv;
    @(posedge clk);
    #1;
    for (int i = 0; i < 19; i++) begin
      exp_p[i] = OKP[i][c[4:3]];
    end
    chk("routed inputs", {5'h00, exp_p}, {5'h00, periph});
    chk("port level", pv, port_level);
    chk("analog pins", pv, analog_pins);
    rd(5'h14 + {3'h0, c[4:3]}, rd_v);
    chk("port read", {16'h0000, 8'h01 << c[2:0]}, {16'h0000, rd_v});
    @(posedge clk);
    analog <= pv;
    @(posedge clk);
    #1;
    chk("analog routed", 24'h000000, {5'h00, periph});
    chk("analog level", 24'h000000, port_level);
    chk("analog fixed", pv, analog_pins);
    @(posedge clk);
    level  <= 24'h000000;
    analog <= 24'h000000;
    $display("test route %h done", c);
  endtask : t_route
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_route(5'h02);
    t_route(5'h0c);
    t_route(5'h13);
    t_route(5'h17);
    conclude();
  end
endmodule : tb
`default_nettype wire
